// ### core/cpl_pct_scale.v
// percentage scaler: limit = setpoint * percent / 100, follows setpoint live
// assumes percent values up to 140 and a 12-bit setpoint code
`timescale 1ns/1ns

module cpl_pct_scale (
    // operands
    input  wire [11:0] setpoint,
    input  wire [7:0]  percent,
    // result
    output wire [12:0] limit
);
    wire [19:0] product;
    wire [19:0] quotient;

    // product then divide; the divide by a constant synthesises to shifts and adds
    assign product  = setpoint * percent;
    assign quotient = product / 20'd100;
    // full scale at 140 percent still fits 13 bits, so the top bits are always zero
    assign limit    = quotient[12:0];
endmodule

// ### core/cpl_protect.v
// protection and warning logic of a step-down point-of-load converter
// assumes measurement codes on the controller clock; pg pin arrives asynchronous
//
// Function
// - at pre-biased turn-on, keep switches off until ramp reference passes output
// - power good upper bit picks 105/110 percent; lower bit picks 95/90 percent
// - overvoltage field maps 00=110, 01=120, 10=130, 11=130 percent
// - undervoltage field maps 00=75, 01=80, 10=85, 11=90 percent
// - protection levels register writable only while modulator stopped
// - voltage limits are percentages of the present output setpoint
// - load droop field bits 7:5 picks droop code 0 to 7
// - bit 4 enables temperature compensation of current limit, default on
// - current limit code bits 3:0, default 0xB gives 140 percent
// - current limit codes above 0xB behave as 0xB
// - warnings only update status, never shut the converter down
// - temperature warning sets above 120 C, clears below 117 C
// - power good pin pulled low when output leaves the window
// - power good checked after steady state, release delayed 0 to 150 ms
// - power good stays active through margining, window follows setpoint
// - warning pulls pin low and status bit 0; restored inside window
// - external low on power good pin counts as a warning
// - option drops power good on turn-off command or on ramp-down start
// - overcurrent past pre-bias clears status bit, switches both sides off
// - undervoltage in steady state without overcurrent starts sequenced ramp-down
// - temperature above 120 C: fault, status bit 0, sequenced ramp-down
// - non-latching overtemperature restarts once below 110 C
// - writing 1 to a fault status bit clears its latched fault
// - non-latching faults retry startup every 130 ms
`timescale 1ns/1ns
`include "cpl_map.vh"

module cpl_protect #(
    parameter RETRY_CYC = `CPL_RETRY_CYC,
    parameter MS_CYC    = `CPL_MS_CYC
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWrEn,
    output reg  [7:0]  regRdData,
    // converter state
    input  wire        runEnable,
    input  wire        turnOnCmd,
    input  wire        steadyState,
    input  wire        rampingDown,
    input  wire [11:0] setpoint,
    input  wire [11:0] rampRef,
    input  wire [11:0] outVoltage,
    input  wire [11:0] outCurrent,
    input  wire [11:0] limitCurrent100,
    input  wire [11:0] ctrlTemp,
    // configuration levels
    input  wire [7:0]  pgDelayMs,
    input  wire        pgDropOnCmd,
    input  wire        otLatching,
    input  wire        ocLatching,
    input  wire        uvLatching,
    // power good open-drain pin
    input  wire        powerGoodIn,
    output reg         powerGoodOut,
    output reg         powerGoodOe,
    // converter control
    output reg         switchesEnable,
    output reg         fastOff,
    output reg         seqRampDown,
    output reg         retryStart,
    output reg  [2:0]  loadDroopSetting,
    output reg         limitTempCompEnable,
    output reg  [12:0] currentLimitAbs
);
    // state codes
    localparam ST_OFF    = 2'd0;
    localparam ST_HOLD   = 2'd1;
    localparam ST_RUN    = 2'd2;
    localparam ST_FAULT  = 2'd3;

    reg  [5:0]  protectionLevelsReg;
    reg  [7:0]  currentLimitReg;
    reg  [7:0]  faultFlagsReg;
    reg  [1:0]  state;
    reg  [22:0] retryCnt;
    reg  [15:0] msCnt;
    reg  [7:0]  pgMsCnt;
    reg         pgReleased;
    reg  [2:0]  pgSync;
    reg         pgExtLow;
    reg         pgSeenHigh;
    reg         ocLatch;
    reg         uvLatch;
    reg         otLatch;

    wire [12:0] pgHiLim;
    wire [12:0] pgLoLim;
    wire [12:0] ovLim;
    wire [12:0] uvLim;
    wire [12:0] ocLim;
    wire [7:0]  pgHiPct;
    wire [7:0]  pgLoPct;
    wire [7:0]  ovPct;
    wire [7:0]  uvPct;
    wire [7:0]  clPct;
    wire [3:0]  clCode;
    wire        inWindow;
    wire        ocTrip;
    wire        uvTrip;
    wire        otTrip;
    wire        pgArmed;
    wire        writeLevels;
    wire        writeLimit;
    wire        writeFlags;

    // current limit code to percent of nominal; codes above 0xB clamp
    function [7:0] clPercent;
        input [3:0] code;
        begin
            if (code > `CPL_CL_MAX) begin
                clPercent = 8'd140;
            end else begin
                clPercent = 8'd37 + {4'h0, code} * 8'd10 - ((code == `CPL_CL_MAX) ? 8'd7 : 8'd0);
            end
        end
    endfunction

    // percent select for the level fields and the current limit code
    assign ovPct = (protectionLevelsReg[`CPL_OV_MSB:`CPL_OV_LSB] == 2'b00) ? 8'd110 :
                   (protectionLevelsReg[`CPL_OV_MSB:`CPL_OV_LSB] == 2'b01) ? 8'd120 : 8'd130;
    assign uvPct = 8'd75 + {4'h0, protectionLevelsReg[`CPL_UV_MSB:`CPL_UV_LSB], 2'b00}
                   + {6'h00, protectionLevelsReg[`CPL_UV_MSB:`CPL_UV_LSB]};
    assign pgHiPct = protectionLevelsReg[`CPL_PG_UPPER_BIT] ? 8'd105 : 8'd110;
    assign pgLoPct = protectionLevelsReg[`CPL_PG_LOWER_BIT] ? 8'd95 : 8'd90;
    assign clCode  = currentLimitReg[`CPL_CL_MSB:`CPL_CL_LSB];
    assign clPct   = clPercent(clCode);

    // voltage limits recomputed every cycle from the live setpoint, current limit from limitCurrent100
    cpl_pct_scale uPgHi (.setpoint(setpoint), .percent(pgHiPct), .limit(pgHiLim));
    cpl_pct_scale uPgLo (.setpoint(setpoint), .percent(pgLoPct), .limit(pgLoLim));
    cpl_pct_scale uOv   (.setpoint(setpoint), .percent(ovPct), .limit(ovLim));
    cpl_pct_scale uUv   (.setpoint(setpoint), .percent(uvPct), .limit(uvLim));
    cpl_pct_scale uOc   (.setpoint(limitCurrent100), .percent(clPct), .limit(ocLim));

    // window and trip conditions
    assign inWindow = ({1'b0, outVoltage} <= pgHiLim) && ({1'b0, outVoltage} >= pgLoLim);
    assign ocTrip   = (state == ST_RUN) && ({1'b0, outCurrent} >= ocLim);
    assign uvTrip   = (state == ST_RUN) && steadyState && !ocTrip && ({1'b0, outVoltage} < uvLim);
    assign otTrip   = ctrlTemp > `CPL_TEMP_FAULT;
    // ramp-down style keeps a released pin through the off command until the output falls
    assign pgArmed  = steadyState && !rampingDown
                      && ((state == ST_RUN && turnOnCmd) || (!pgDropOnCmd && pgReleased));

    // register strobes; levels write refused while modulating
    assign writeLevels = regWrEn && (regAddr == `CPL_PROT_LEVELS_ADDR) && !runEnable;
    assign writeLimit  = regWrEn && (regAddr == `CPL_CUR_LIMIT_ADDR);
    assign writeFlags  = regWrEn && (regAddr == `CPL_FAULT_FLAGS_ADDR);

    // configuration registers
    always @(posedge clk) begin
        if (!rst_n) begin
            protectionLevelsReg <= `CPL_PROT_LEVELS_RST;
            currentLimitReg     <= `CPL_CUR_LIMIT_RST;
        end else begin
            if (writeLevels) begin
                protectionLevelsReg <= regWrData[5:0];
            end
            if (writeLimit) begin
                currentLimitReg <= regWrData;
            end
        end
    end

    // configuration outputs registered so they come from flip-flops
    always @(posedge clk) begin
        if (!rst_n) begin
            loadDroopSetting    <= 3'h0;
            limitTempCompEnable <= 1'b1;
            currentLimitAbs     <= 13'h0000;
        end else begin
            loadDroopSetting    <= currentLimitReg[`CPL_DROOP_MSB:`CPL_DROOP_LSB];
            limitTempCompEnable <= currentLimitReg[`CPL_TCOMP_BIT];
            currentLimitAbs     <= ocLim;
        end
    end

    // pg pin synchroniser; stage 0 feeds stage 1 only
    // an outside low counts only once our release was seen high, else sync lag reads our own pull
    always @(posedge clk) begin
        if (!rst_n) begin
            pgSync     <= 3'b111;
            pgExtLow   <= 1'b0;
            pgSeenHigh <= 1'b0;
        end else begin
            pgSync <= {pgSync[1:0], powerGoodIn};
            if (!pgReleased) begin
                pgSeenHigh <= 1'b0;
            end else if (pgSync[2] && pgSync[1]) begin
                pgSeenHigh <= 1'b1;
            end
            if (pgSync[2] == pgSync[1]) begin
                pgExtLow <= !pgSync[1] && pgSeenHigh;
            end
        end
    end

    // pg release delay in whole ms after the window is met in steady state
    always @(posedge clk) begin
        if (!rst_n) begin
            msCnt      <= 16'h0000;
            pgMsCnt    <= 8'h00;
            pgReleased <= 1'b0;
        end else if (!pgArmed || !inWindow) begin
            msCnt      <= 16'h0000;
            pgMsCnt    <= 8'h00;
            pgReleased <= 1'b0;
        end else if (!pgReleased) begin
            if (pgMsCnt >= pgDelayMs || pgMsCnt >= `CPL_PG_DELAY_MAX_MS) begin
                pgReleased <= 1'b1;
            end else if (msCnt == MS_CYC[15:0] - 16'h0001) begin
                msCnt   <= 16'h0000;
                pgMsCnt <= pgMsCnt + 8'h01;
            end else begin
                msCnt <= msCnt + 16'h0001;
            end
        end
    end

    // pin drive: open drain, low while not good
    always @(posedge clk) begin
        if (!rst_n) begin
            powerGoodOut <= 1'b0;
            powerGoodOe  <= 1'b1;
        end else begin
            powerGoodOut <= 1'b0;
            powerGoodOe  <= !pgReleased;
        end
    end

    // status flags; hardware set of a fault wins over a software clear
    always @(posedge clk) begin
        if (!rst_n) begin
            faultFlagsReg <= `CPL_FAULT_FLAGS_RST;
            ocLatch       <= 1'b0;
            uvLatch       <= 1'b0;
            otLatch       <= 1'b0;
        end else begin
            // warnings only touch status bits, never the run state
            if (ctrlTemp > `CPL_TEMP_WARN_ON) begin
                faultFlagsReg[`CPL_ST_TW] <= 1'b1;
            end else if (ctrlTemp < `CPL_TEMP_WARN_OFF) begin
                faultFlagsReg[`CPL_ST_TW] <= 1'b0;
            end
            faultFlagsReg[`CPL_ST_PG] <= pgReleased && !pgExtLow;
            if (ocTrip) begin
                faultFlagsReg[`CPL_ST_OC] <= 1'b0;
                ocLatch <= ocLatching;
            end else if (writeFlags && regWrData[`CPL_ST_OC]) begin
                faultFlagsReg[`CPL_ST_OC] <= 1'b1;
                ocLatch <= 1'b0;
            end
            if (uvTrip) begin
                faultFlagsReg[`CPL_ST_UV] <= 1'b0;
                uvLatch <= uvLatching;
            end else if (writeFlags && regWrData[`CPL_ST_UV]) begin
                faultFlagsReg[`CPL_ST_UV] <= 1'b1;
                uvLatch <= 1'b0;
            end
            if (otTrip) begin
                faultFlagsReg[`CPL_ST_OT] <= 1'b0;
                otLatch <= otLatching;
            end else if (writeFlags && regWrData[`CPL_ST_OT]) begin
                faultFlagsReg[`CPL_ST_OT] <= 1'b1;
                otLatch <= 1'b0;
            end
        end
    end

    // register read mux; unmapped offsets read zero
    always @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else begin
            case (regAddr)
                `CPL_PROT_LEVELS_ADDR: regRdData <= {2'b00, protectionLevelsReg};
                `CPL_CUR_LIMIT_ADDR:   regRdData <= currentLimitReg;
                `CPL_FAULT_FLAGS_ADDR: regRdData <= faultFlagsReg;
                default:               regRdData <= 8'h00;
            endcase
        end
    end

    // converter run state with pre-bias hold-off and retry
    always @(posedge clk) begin
        if (!rst_n) begin
            state          <= ST_OFF;
            retryCnt       <= 23'h000000;
            switchesEnable <= 1'b0;
            fastOff        <= 1'b0;
            seqRampDown    <= 1'b0;
            retryStart     <= 1'b0;
        end else begin
            fastOff    <= 1'b0;
            retryStart <= 1'b0;
            case (state)
                ST_OFF: begin
                    seqRampDown <= 1'b0;
                    if (turnOnCmd && !otTrip && !ocLatch && !uvLatch && !otLatch) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // stage held off so a pre-biased rail is not discharged
                    if (!turnOnCmd) begin
                        state <= ST_OFF;
                    end else if (rampRef >= outVoltage) begin
                        state          <= ST_RUN;
                        switchesEnable <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (ocTrip) begin
                        switchesEnable <= 1'b0;
                        fastOff        <= 1'b1;
                        state          <= ST_FAULT;
                        retryCnt       <= 23'h000000;
                    end else if (uvTrip || otTrip) begin
                        seqRampDown <= 1'b1;
                        state       <= ST_FAULT;
                        retryCnt    <= 23'h000000;
                    end else if (!turnOnCmd) begin
                        switchesEnable <= 1'b0;
                        state          <= ST_OFF;
                    end
                end
                ST_FAULT: begin
                    if (!rampingDown) begin
                        switchesEnable <= 1'b0;
                    end
                    if (!turnOnCmd) begin
                        state <= ST_OFF;
                    end else if (otTrip || ctrlTemp >= `CPL_TEMP_RESTART || otLatch) begin
                        // over-temperature waits for cool-down below restart level
                        retryCnt <= 23'h000000;
                    end else if (retryCnt >= RETRY_CYC[22:0] - 23'h000001) begin
                        if (!ocLatch && !uvLatch) begin
                            retryStart  <= 1'b1;
                            seqRampDown <= 1'b0;
                            state       <= ST_HOLD;
                        end
                        retryCnt <= 23'h000000;
                    end else begin
                        retryCnt <= retryCnt + 23'h000001;
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end
endmodule

// ### pkg/cpl_map.vh
// constants for the converter protection logic: register offsets, fields, resets, timing
// assumes a 20 MHz controller clock and 12-bit converter-side measurement codes
`ifndef CPL_MAP_VH
`define CPL_MAP_VH

// register offsets
`define CPL_PROT_LEVELS_ADDR   8'h01
`define CPL_CUR_LIMIT_ADDR     8'h08
`define CPL_FAULT_FLAGS_ADDR   8'h16

// reset values
`define CPL_PROT_LEVELS_RST    6'h08
`define CPL_CUR_LIMIT_RST      8'h1b
`define CPL_FAULT_FLAGS_RST    8'h7f

// protection level field positions
`define CPL_PG_UPPER_BIT       5
`define CPL_PG_LOWER_BIT       4
`define CPL_OV_MSB             3
`define CPL_OV_LSB             2
`define CPL_UV_MSB             1
`define CPL_UV_LSB             0

// current limit field positions
`define CPL_DROOP_MSB          7
`define CPL_DROOP_LSB          5
`define CPL_TCOMP_BIT          4
`define CPL_CL_MSB             3
`define CPL_CL_LSB             0
`define CPL_CL_MAX             4'hb

// status bit positions
`define CPL_ST_TW              7
`define CPL_ST_PG              6
`define CPL_ST_OT              4
`define CPL_ST_OC              3
`define CPL_ST_UV              2

// temperatures in degrees C
`define CPL_TEMP_WARN_ON       12'd120
`define CPL_TEMP_WARN_OFF      12'd117
`define CPL_TEMP_FAULT         12'd120
`define CPL_TEMP_RESTART       12'd110

// timing
`define CPL_CLK_HZ             20000000
`define CPL_RETRY_MS           130
`define CPL_RETRY_CYC          ((`CPL_RETRY_MS * (`CPL_CLK_HZ / 1000)))
`define CPL_PG_DELAY_MAX_MS    8'd150
`define CPL_MS_CYC             (`CPL_CLK_HZ / 1000)

`endif

// ### test/converter_protection_logic_test.sv
// self-checking bench for the converter protection block
// assumes a 20 MHz clock and shortened retry and millisecond counts
`timescale 1ns/1ns

module converter_protection_logic_test;
    logic        clk, rst_n, regWrEn, runEnable, turnOnCmd, steadyState, rampingDown, pgDropOnCmd;
    logic        otLatching, ocLatching, uvLatching, powerGoodIn, powerGoodOut, powerGoodOe, switchesEnable;
    logic        fastOff, seqRampDown, retryStart, limitTempCompEnable;
    logic [7:0]  regAddr, regWrData, regRdData, pgDelayMs, d;
    logic [11:0] setpoint, rampRef, outVoltage, outCurrent, limitCurrent100, ctrlTemp;
    logic [2:0]  loadDroopSetting;
    logic [12:0] currentLimitAbs;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n;

    cpl_protect #(.RETRY_CYC(50), .MS_CYC(10)) i_dut (.clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdData,
        .runEnable, .turnOnCmd, .steadyState, .rampingDown, .setpoint, .rampRef, .outVoltage, .outCurrent,
        .limitCurrent100, .ctrlTemp, .pgDelayMs, .pgDropOnCmd, .otLatching, .ocLatching, .uvLatching,
        .powerGoodIn, .powerGoodOut, .powerGoodOe, .switchesEnable, .fastOff, .seqRampDown, .retryStart,
        .loadDroopSetting, .limitTempCompEnable, .currentLimitAbs);
    cpl_host_model i_host (.clk, .regAddr, .regWrData, .regWrEn, .regRdData, .powerGoodOe, .powerGoodIn);

    task final_report;
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task cmp(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // let the edge's updates land before looking
    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function logic pick(input int s);
        case (s)
            0: pick = switchesEnable;
            1: pick = powerGoodOe;
            2: pick = fastOff;
            3: pick = retryStart;
            default: pick = seqRampDown;
        endcase
    endfunction

    // bounded wait on one output; n holds the cycles spent
    task waitBit(input int s, input logic v, input int lim);
        for (n = 0; n < lim && pick(s) !== v; n++)
            tick(1);
    endtask

    task t_regs;
        logic [7:0] a [4] = '{8'h01, 8'h08, 8'h16, 8'h20};
        logic [7:0] e [4] = '{8'h08, 8'h1b, 8'h3f, 8'h00};
        foreach (a[k]) begin
            i_host.rd(a[k], d);
            cmp(d, e[k]);
        end
    endtask

    task t_levels;
        @(posedge clk) runEnable <= 1'b1;
        i_host.wr(8'h01, 8'h3f);
        i_host.rd(8'h01, d);
        cmp(d, 8'h08);
        @(posedge clk) runEnable <= 1'b0;
        i_host.wr(8'h01, 8'hff);
        i_host.rd(8'h01, d);
        cmp(d, 8'h3f);
        i_host.wr(8'h01, 8'h08);
    endtask

    // codes above the top one behave as the top one
    task t_limit;
        logic [3:0] c [4] = '{4'h0, 4'h1, 4'hb, 4'hf};
        foreach (c[k]) begin
            i_host.wr(8'h08, {4'he, c[k]});
            tick(4);
            cmp(loadDroopSetting, 3'h7);
            cmp(limitTempCompEnable, 1'b0);
            cmp(currentLimitAbs, c[k] >= 4'hb ? 13'd140 : 13'd37 + 13'd10 * c[k]);
        end
        i_host.wr(8'h08, 8'h1b);
    endtask

    task t_run;
        @(posedge clk) outVoltage <= 12'd900;
        turnOnCmd <= 1'b1;
        tick(6);
        cmp(switchesEnable, 1'b0);
        @(posedge clk) rampRef <= 12'd1000;
        waitBit(0, 1'b1, 4);
        cmp(switchesEnable, 1'b1);
        @(posedge clk) steadyState <= 1'b1;
        outVoltage <= 12'd1080;
        tick(10);
        cmp(powerGoodOe, 1'b1);
        waitBit(1, 1'b0, 40);
        cmp(powerGoodOe, 1'b0);
        // margin down: same output now above the moved upper limit
        @(posedge clk) setpoint <= 12'd950;
        waitBit(1, 1'b1, 5);
        cmp(powerGoodOe, 1'b1);
        i_host.rd(8'h16, d);
        cmp(d[6], 1'b0);
        cmp(switchesEnable, 1'b1);
        @(posedge clk) setpoint <= 12'd1000;
        waitBit(1, 1'b0, 40);
        i_host.rd(8'h16, d);
        cmp(d[6], 1'b1);
        @(posedge clk) i_host.extLow <= 1'b1;
        tick(5); // let the pin synchroniser agree
        i_host.rd(8'h16, d);
        cmp(d[6], 1'b0);
        @(posedge clk) i_host.extLow <= 1'b0;
        waitBit(1, 1'b0, 40);
    endtask

    task t_temp;
        @(posedge clk) ctrlTemp <= 12'd121;
        waitBit(4, 1'b1, 3);
        cmp(seqRampDown, 1'b1);
        i_host.rd(8'h16, d);
        cmp(d[7:4], 4'ha);
        @(posedge clk) ctrlTemp <= 12'd118;
        i_host.rd(8'h16, d);
        cmp(d[7], 1'b1);
        @(posedge clk) ctrlTemp <= 12'd116;
        i_host.rd(8'h16, d);
        cmp(d[7], 1'b0);
        tick(80);
        cmp(switchesEnable, 1'b0);
        @(posedge clk) ctrlTemp <= 12'd100;
        waitBit(3, 1'b1, 100);
        cmp(retryStart, 1'b1);
        i_host.wr(8'h16, 8'h10);
        i_host.rd(8'h16, d);
        cmp(d[4], 1'b1);
        @(posedge clk) rampRef <= 12'd1100;
        waitBit(0, 1'b1, 10);
        cmp(switchesEnable, 1'b1);
    endtask

    task t_oc;
        @(posedge clk) outCurrent <= 12'd200;
        waitBit(2, 1'b1, 3);
        cmp(switchesEnable, 1'b0);
        @(posedge clk) outCurrent <= 12'd0;
        waitBit(3, 1'b1, 80);
        cmp(n inside {[46:52]}, 1'b1);
        i_host.rd(8'h16, d);
        cmp(d[3], 1'b0);
        i_host.wr(8'h16, 8'h08);
        i_host.rd(8'h16, d);
        cmp(d[3], 1'b1);
        // output sags below the undervoltage limit in steady state
        @(posedge clk) outVoltage <= 12'd700;
        waitBit(4, 1'b1, 3);
        cmp(seqRampDown, 1'b1);
        i_host.rd(8'h16, d);
        cmp(d[2], 1'b0);
        @(posedge clk) outVoltage <= 12'd1080;
        waitBit(0, 1'b1, 80);
        cmp(switchesEnable, 1'b1);
        waitBit(1, 1'b0, 60);
        // drop on the command itself, no ramp-down seen yet
        @(posedge clk) turnOnCmd <= 1'b0;
        waitBit(1, 1'b1, 3);
        cmp(powerGoodOe, 1'b1);
        // ramp-down style: pin stays released until the output starts falling
        @(posedge clk) pgDropOnCmd <= 1'b0;
        turnOnCmd <= 1'b1;
        waitBit(1, 1'b0, 60);
        cmp(powerGoodOe, 1'b0);
        @(posedge clk) turnOnCmd <= 1'b0;
        tick(3);
        cmp(powerGoodOe, 1'b0);
        @(posedge clk) rampingDown <= 1'b1;
        waitBit(1, 1'b1, 3);
        cmp(powerGoodOe, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report;
        end
    end

    initial begin
        {rst_n, runEnable, turnOnCmd, steadyState, rampingDown} = 5'h00;
        {otLatching, ocLatching, uvLatching, pgDropOnCmd} = 4'h1;
        setpoint = 12'd1000;
        rampRef = 12'd500;
        outVoltage = 12'd0;
        outCurrent = 12'd0;
        limitCurrent100 = 12'd100;
        ctrlTemp = 12'd25;
        pgDelayMs = 8'h02;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_levels;
        t_limit;
        t_run;
        t_temp;
        t_oc;
        final_report;
    end
endmodule

// ### test/cpl_host_model.sv
// power manager host: register accesses and an outside pull on the power good line
// assumes requests start after reset release, launched at rising edges
`timescale 1ns/1ns

module cpl_host_model (
    // clock
    input wire logic        clk,
    // register port
    output logic     [7:0]  regAddr,
    output logic     [7:0]  regWrData,
    output logic            regWrEn,
    input wire logic [7:0]  regRdData,
    // power good line
    input wire logic        powerGoodOe,
    output wire logic       powerGoodIn
);
    logic extLow;

    // pull-up line: low when either party pulls
    assign powerGoodIn = !(powerGoodOe || extLow);

    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        extLow = 1'b0;
    end

    // one-cycle write strobe, address and data held with it
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask

    // data stands while the address holds, so sample after two edges
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        repeat (2) @(posedge clk);
        #1 d = regRdData;
    endtask
endmodule

// ### test/cpl_protect_props.sv
// concurrent checks on the protection block ports
// assumes one clock domain and is bound into every cpl_protect
`timescale 1ns/1ns

module cpl_protect_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrEn,
    // converter state
    input wire logic [11:0] rampRef,
    input wire logic [11:0] outVoltage,
    input wire logic [11:0] outCurrent,
    input wire logic [11:0] ctrlTemp,
    // watched outputs
    input wire logic        powerGoodOut,
    input wire logic        switchesEnable,
    input wire logic        fastOff,
    input wire logic        seqRampDown,
    input wire logic        retryStart,
    input wire logic [2:0]  loadDroopSetting,
    input wire logic        limitTempCompEnable,
    input wire logic [12:0] currentLimitAbs
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // switches only come on once the ramp has passed the output
    property p_preBias;
        $rose(switchesEnable) |-> $past(rampRef) >= $past(outVoltage);
    endproperty
    a_preBias: assert property (p_preBias) else $error("switches on below pre-bias");

    // droop and compensation copies follow a limit write two cycles on
    property p_cfgCopy;
        regWrEn && regAddr == 8'h08 |-> ##2 {4'h0, loadDroopSetting, limitTempCompEnable} == ($past(regWrData, 2) >> 4);
    endproperty
    a_cfgCopy: assert property (p_cfgCopy) else $error("limit register copy wrong");

    // open drain: the pin is only ever pulled low
    property p_pgOut;
        powerGoodOut == 1'b0;
    endproperty
    a_pgOut: assert property (p_pgOut) else $error("power good driven high");

    // current at the limit while running trips the fast off
    property p_ocTrip;
        switchesEnable && {1'b0, outCurrent} >= currentLimitAbs |-> ##[1:2] fastOff;
    endproperty
    a_ocTrip: assert property (p_ocTrip) else $error("overcurrent not tripped");

    property p_fastPulse;
        fastOff |=> !fastOff;
    endproperty
    a_fastPulse: assert property (p_fastPulse) else $error("fast off longer than one cycle");

    property p_fastOffSw;
        fastOff |-> !switchesEnable;
    endproperty
    a_fastOffSw: assert property (p_fastOffSw) else $error("switches on during fast off");

    // hot controller while running asks for a sequenced ramp-down
    property p_otRamp;
        switchesEnable && ctrlTemp > 12'd120 |-> ##[1:3] seqRampDown;
    endproperty
    a_otRamp: assert property (p_otRamp) else $error("overtemperature ramp-down missing");

    property p_retryPulse;
        retryStart |=> !retryStart;
    endproperty
    a_retryPulse: assert property (p_retryPulse) else $error("retry longer than one cycle");
endmodule

bind cpl_protect cpl_protect_props u_props (.clk, .rst_n, .regAddr, .regWrData, .regWrEn, .rampRef, .outVoltage,
    .outCurrent, .ctrlTemp, .powerGoodOut, .switchesEnable, .fastOff, .seqRampDown, .retryStart, .loadDroopSetting,
    .limitTempCompEnable, .currentLimitAbs);
